// >>> core/csp_device.sv
/*
 * Device end of the serial configuration port with a small byte register file.
 * Assumes sclk and chip select come from another domain; all are sampled by
 * clk_sys through three flops. Register 0 selects the bit order.
 */
// Register access over AHB-Lite was chosen for this implementation.
// Function
// - Frame starts at select low plus rising clock.
// - Sixteen-bit instruction, then length-coded data bytes.
// - Length code 11 streams until select rises.
// - Select stall between bytes keeps frame position, except when streaming.
// - Select rise mid-byte discards the frame.
// - Two-wire mode with select held low works.
// - Host avoids streaming in two-wire mode.
// - Instruction carries read/write indicator and length.
// - Read turns data line to output after instruction.
// - MSB first default; register zero selects LSB.
// - Input bits captured at rising serial clock.
// - Drive after falling edge, release after rising.
// - Register space is byte-wide, one per address.
// - MSB streaming addresses start at block top.
module csp_device (
    // System
    input wire logic clk_sys,
    input wire logic reset,
    // Link
    csp_link_if.device link,
    // User side: register view
    output logic [7:0] cfgReg_q,
    output logic writeStrobe_q,
    output logic [12:0] writeAddr_q,
    output logic [7:0] writeData_q
);
    typedef enum logic [1:0] {CSP_IDLE, CSP_INSTR, CSP_DATA} csp_state_t;
    localparam int REG_COUNT_L = csp_pkg::REG_COUNT;

    logic [2:0] sclkSync_q, csSync_q, sdiSync_q;
    logic sclkLvl_q, csLvl_q;
    logic sclkRise, sclkFall, csHigh;
    logic sdiBit;
    csp_state_t state_q;
    logic [3:0] bitCnt_q;
    logic [15:0] shift_q;
    logic readOp_q;
    logic [1:0] lenCode_q;
    logic [1:0] bytesDone_q;
    logic [12:0] addr_q;
    logic [7:0] txByte_q;
    logic [7:0] regs_q [REG_COUNT_L];
    logic lsbFirst;
    logic [15:0] instrWord;
    logic [7:0] dataByte;
    logic [7:0] rdByte;
    logic [7:0] nextTx;
    logic lastByte;
    logic [12:0] nextAddr;

    // Three-flop sampling; a change counts when the second and third agree.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sclkSync_q <= 3'h0;
            csSync_q <= 3'h7;
            sdiSync_q <= 3'h0;
            sclkLvl_q <= 1'b0;
            csLvl_q <= 1'b1;
        end else begin
            sclkSync_q <= {sclkSync_q[1:0], link.sclk};
            csSync_q <= {csSync_q[1:0], link.chipSelectN};
            sdiSync_q <= {sdiSync_q[1:0], link.sdioLine};
            if (sclkSync_q[1] == sclkSync_q[2]) begin
                sclkLvl_q <= sclkSync_q[2];
            end
            if (csSync_q[1] == csSync_q[2]) begin
                csLvl_q <= csSync_q[2];
            end
        end
    end

    assign csHigh = csLvl_q;
    // Clock ignored while select is high.
    assign sclkRise = !sclkLvl_q && sclkSync_q[1] && sclkSync_q[2] && !csHigh;
    assign sclkFall = sclkLvl_q && !sclkSync_q[1] && !sclkSync_q[2] && !csHigh;
    assign sdiBit = sdiSync_q[2];
    assign lsbFirst = regs_q[0][csp_pkg::CFG_LSB_FIRST_POS];

    // Assemble words so bit 15 / bit 7 is always the MSB whatever the wire order.
    // In LSB order bits enter at the top, so a byte's earlier bits sit in 15:9.
    always_comb begin
        if (lsbFirst) begin
            instrWord = {sdiBit, shift_q[15:1]};
            dataByte = {sdiBit, shift_q[15:9]};
        end else begin
            instrWord = {shift_q[14:0], sdiBit};
            dataByte = {shift_q[6:0], sdiBit};
        end
    end

    assign rdByte = (addr_q < 13'(REG_COUNT_L)) ? regs_q[addr_q[3:0]] : 8'h00;
    assign lastByte = (lenCode_q != csp_pkg::LEN_STREAM) && (bytesDone_q == lenCode_q);
    // Streaming steps down in MSB mode, up in LSB mode.
    assign nextAddr = lsbFirst ? addr_q + 13'h0001 : addr_q - 13'h0001;

    // Frame state machine, advanced on rising serial clock.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q <= CSP_IDLE;
            bitCnt_q <= 4'h0;
            shift_q <= 16'h0000;
            readOp_q <= 1'b0;
            lenCode_q <= 2'h0;
            bytesDone_q <= 2'h0;
            addr_q <= 13'h0000;
        end else if (csHigh && bitCnt_q != 4'h0) begin
            state_q <= CSP_IDLE;
            bitCnt_q <= 4'h0;
        end else if (csHigh && state_q == CSP_DATA && lenCode_q == csp_pkg::LEN_STREAM) begin
            state_q <= CSP_IDLE;
        end else if (sclkRise) begin
            shift_q <= {shift_q[14:0], sdiBit};
            if (lsbFirst) begin
                shift_q <= {sdiBit, shift_q[15:1]};
            end
            bitCnt_q <= bitCnt_q + 4'h1;
            case (state_q)
                CSP_IDLE: begin
                    state_q <= CSP_INSTR;
                    bitCnt_q <= 4'h1;
                    shift_q <= {15'h0000, sdiBit};
                    if (lsbFirst) begin
                        shift_q <= {sdiBit, 15'h0000};
                    end
                end
                CSP_INSTR: begin
                    if (bitCnt_q == 4'hF) begin
                        // Read/write indicator and length decoded.
                        readOp_q <= instrWord[csp_pkg::INSTR_RW_POS];
                        lenCode_q <= {instrWord[csp_pkg::INSTR_LEN_HI_POS],
                            instrWord[csp_pkg::INSTR_LEN_LO_POS]};
                        addr_q <= instrWord[12:0];
                        bytesDone_q <= 2'h0;
                        state_q <= CSP_DATA;
                        bitCnt_q <= 4'h0;
                    end
                end
                default: begin
                    if (bitCnt_q == 4'h7) begin
                        bitCnt_q <= 4'h0; // Byte boundary: a select stall here is kept unless streaming.
                        bytesDone_q <= bytesDone_q + 2'h1;
                        addr_q <= nextAddr;
                        if (lastByte) begin
                            state_q <= CSP_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Register writes at the end of each written byte.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < REG_COUNT_L; i++) begin
                regs_q[i] <= csp_pkg::REG_RESET;
            end
            writeStrobe_q <= 1'b0;
            writeAddr_q <= 13'h0000;
            writeData_q <= 8'h00;
        end else begin
            writeStrobe_q <= 1'b0;
            if (sclkRise && state_q == CSP_DATA && bitCnt_q == 4'h7 && !readOp_q) begin
                writeStrobe_q <= 1'b1;
                writeAddr_q <= addr_q;
                writeData_q <= dataByte;
                if (addr_q < 13'(REG_COUNT_L)) begin
                    regs_q[addr_q[3:0]] <= dataByte;
                end
            end
        end
    end

    assign cfgReg_q = regs_q[0];

    // Read byte loaded after the instruction or after each byte; shifted on falls.
    always_comb begin
        nextTx = lsbFirst ? {1'b0, txByte_q[7:1]} : {txByte_q[6:0], 1'b0};
    end

    // Data line driven only for reads, from a falling edge, released at the last byte's rising edge or at select rise.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            txByte_q <= 8'h00;
            link.devSdo <= 1'b0;
            link.devSdoEn <= 1'b0;
        end else if (csHigh || state_q != CSP_DATA || !readOp_q) begin
            link.devSdoEn <= 1'b0;
            txByte_q <= rdByte;
        end else if (sclkFall) begin
            link.devSdoEn <= 1'b1;
            if (bitCnt_q == 4'h0) begin
                link.devSdo <= lsbFirst ? rdByte[0] : rdByte[7];
                txByte_q <= lsbFirst ? {1'b0, rdByte[7:1]} : {rdByte[6:0], 1'b0};
            end else begin
                link.devSdo <= lsbFirst ? txByte_q[0] : txByte_q[7];
                txByte_q <= nextTx;
            end
        end else if (sclkRise && bitCnt_q == 4'h7 && lastByte) begin
            link.devSdoEn <= 1'b0;
        end
    end
endmodule

// >>> core/csp_host.sv
/*
 * Host end: an AHB-Lite slave register set that launches one serial frame.
 * Makes the serial clock by dividing clk_sys. Assumes a single AHB master.
 */
module csp_host (
    // System
    input wire logic clk_sys,
    input wire logic reset,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic hready,
    // Link
    csp_link_if.host link
);
    typedef enum logic [1:0] {CSPH_IDLE, CSPH_SHIFT, CSPH_GAP} csph_state_t;

    logic [15:0] cmd_q;
    logic [23:0] wdata_q, rdata_q;
    logic [1:0] ctrl_q;
    logic busy_q;
    logic startReq_q;
    logic wrPend_q;
    logic [7:0] wrAddr_q;
    logic [2:0] syncIn_q;
    csph_state_t state_q;
    logic [7:0] divCnt_q;
    logic [5:0] bitsLeft_q;
    logic [39:0] txShift_q;
    logic [5:0] dataBits;
    logic [5:0] readStart;
    logic [7:0] phaseIdx;
    logic lsbOut;
    logic [15:0] cmdOrdered;
    logic [23:0] wdataOrdered, rdataOrdered;

    assign hresp = 1'b0;
    // One 24-bit data word holds up to three bytes, right-aligned; the first sent sits in bits 23:16, 15:8 or 7:0 for three, two or one.
    assign dataBits = 6'(8 * (32'(cmd_q[14:13]) + 1));
    assign readStart = 6'(bitsLeft_q);
    assign lsbOut = ctrl_q[csp_pkg::CTRL_LSB_FIRST_POS];

    // LSB order mirrors each unit: the instruction as one word, data byte by byte.
    for (genvar b = 0; b < 24; b++) begin : g_order
        if (b < 16) begin : g_cmd
            assign cmdOrdered[b] = lsbOut ? cmd_q[15 - b] : cmd_q[b];
        end
        assign wdataOrdered[b] = lsbOut ? wdata_q[b ^ 7] : wdata_q[b];
        assign rdataOrdered[b] = lsbOut ? rdata_q[b ^ 7] : rdata_q[b];
    end

    // AHB-Lite address and data phases; zero wait states.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            cmd_q <= 16'h0000;
            wdata_q <= 24'h00_0000;
            ctrl_q <= 2'h0;
            startReq_q <= 1'b0;
        end else begin
            startReq_q <= 1'b0;
            if (wrPend_q) begin
                if (wrAddr_q == csp_pkg::HOST_CMD_OFS) begin
                    cmd_q <= hwdata[15:0];
                    startReq_q <= hwdata[csp_pkg::CMD_START_POS];
                end else if (wrAddr_q == csp_pkg::HOST_WDATA_OFS) begin
                    wdata_q <= hwdata[23:0];
                end else if (wrAddr_q == csp_pkg::HOST_CTRL_OFS) begin
                    ctrl_q <= hwdata[1:0];
                end
            end
            wrPend_q <= 1'b0;
            if (hready && hsel && htrans[1]) begin
                wrPend_q <= hwrite;
                wrAddr_q <= haddr[7:0];
                if (!hwrite) begin
                    if (haddr[7:0] == csp_pkg::HOST_CMD_OFS) begin
                        hrdata <= {16'h0000, cmd_q};
                    end else if (haddr[7:0] == csp_pkg::HOST_WDATA_OFS) begin
                        hrdata <= {8'h00, wdata_q};
                    end else if (haddr[7:0] == csp_pkg::HOST_RDATA_OFS) begin
                        hrdata <= {8'h00, rdataOrdered};
                    end else if (haddr[7:0] == csp_pkg::HOST_STATUS_OFS) begin
                        hrdata <= {31'h0000_0000, busy_q};
                    end else if (haddr[7:0] == csp_pkg::HOST_CTRL_OFS) begin
                        hrdata <= {30'h0000_0000, ctrl_q};
                    end else begin
                        hrdata <= 32'h0000_0000;
                    end
                end
            end
        end
    end

    // Read data line sampled through three flops.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            syncIn_q <= 3'h0;
        end else begin
            syncIn_q <= {syncIn_q[1:0], link.sdioLine};
        end
    end

    assign phaseIdx = 8'(csp_pkg::SCLK_HALF_CYC - 1);

    // Frame engine: data changes on falling sclk, device samples on rising.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q <= CSPH_IDLE;
            busy_q <= 1'b0;
            divCnt_q <= 8'h00;
            bitsLeft_q <= 6'h00;
            txShift_q <= 40'h00_0000_0000;
            rdata_q <= 24'h00_0000;
            link.sclk <= 1'b0;
            link.chipSelectN <= 1'b1;
            link.hostSdo <= 1'b0;
            link.hostSdoEn <= 1'b0;
        end else begin
            case (state_q)
                CSPH_IDLE: begin
                    link.sclk <= 1'b0;
                    link.chipSelectN <= !ctrl_q[csp_pkg::CTRL_HOLD_CS_POS];
                    if (startReq_q) begin
                        busy_q <= 1'b1;
                        rdata_q <= 24'h00_0000;
                        bitsLeft_q <= 6'(6'd16 + dataBits);
                        link.chipSelectN <= 1'b0;
                        link.hostSdoEn <= 1'b1;
                        link.hostSdo <= cmdOrdered[15];
                        txShift_q <= {cmdOrdered[14:0], wdataOrdered << (6'd24 - dataBits), 1'b0};
                        divCnt_q <= 8'h00;
                        state_q <= CSPH_SHIFT;
                    end
                end
                CSPH_SHIFT: begin
                    divCnt_q <= divCnt_q + 8'h01;
                    if (divCnt_q == phaseIdx) begin
                        divCnt_q <= 8'h00;
                        link.sclk <= !link.sclk;
                        if (!link.sclk) begin
                            bitsLeft_q <= bitsLeft_q - 6'h01;
                        end else if (bitsLeft_q == 6'h00) begin
                            link.hostSdoEn <= 1'b0;
                            state_q <= CSPH_GAP;
                        end else begin
                            link.hostSdo <= txShift_q[39];
                            txShift_q <= {txShift_q[38:0], 1'b0};
                            link.hostSdoEn <= !(cmd_q[csp_pkg::CMD_RW_POS]
                                && bitsLeft_q <= dataBits);
                        end
                    end
                    // Read bits sampled just before the rising edge.
                    if (divCnt_q == phaseIdx && !link.sclk && cmd_q[csp_pkg::CMD_RW_POS]
                        && readStart <= dataBits) begin
                        rdata_q <= {rdata_q[22:0], syncIn_q[2]};
                    end
                end
                default: begin
                    link.sclk <= 1'b0;
                    link.chipSelectN <= !ctrl_q[csp_pkg::CTRL_HOLD_CS_POS];
                    divCnt_q <= divCnt_q + 8'h01;
                    if (divCnt_q == 8'(csp_pkg::CS_GAP_CYC)) begin
                        busy_q <= 1'b0;
                        state_q <= CSPH_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// >>> core/csp_link_if.sv
/*
 * Link between the host controller and the device port: serial clock,
 * active-low chip select and the shared data line split into in/out/enable.
 * The interface itself resolves the data line from the two enables.
 */
interface csp_link_if;
    logic sclk;
    logic chipSelectN;
    logic hostSdo;
    logic hostSdoEn;
    logic devSdo;
    logic devSdoEn;
    logic sdioLine;

    // The wire is driven by whichever end enables; idle level is low.
    assign sdioLine = hostSdoEn ? hostSdo : (devSdoEn ? devSdo : 1'b0);

    modport device (input sclk, input chipSelectN, input sdioLine,
        output devSdo, output devSdoEn);
    modport host (output sclk, output chipSelectN, output hostSdo,
        output hostSdoEn, input sdioLine);
endinterface

// >>> core/csp_pkg.sv
/*
 * Shared constants for the serial configuration port: instruction layout,
 * transfer lengths, register offsets and reset values, link timing.
 * Assumes a 100 MHz system clock on both ends and an 8-bit register space.
 */
package csp_pkg;
    // Instruction word layout (16 bits, first bit on the wire is bit 15 in MSB mode).
    localparam int INSTR_BITS = 16;
    localparam int INSTR_RW_POS = 15;
    localparam int INSTR_LEN_HI_POS = 14;
    localparam int INSTR_LEN_LO_POS = 13;
    localparam int ADDR_BITS = 13;
    // Transfer length codes held in the two length bits.
    localparam logic [1:0] LEN_ONE = 2'h0;
    localparam logic [1:0] LEN_TWO = 2'h1;
    localparam logic [1:0] LEN_THREE = 2'h2;
    localparam logic [1:0] LEN_STREAM = 2'h3;
    // Device register space.
    localparam int REG_COUNT = 16;
    localparam logic [12:0] SERIAL_PORT_CONFIG_ADDR = 13'h0000;
    localparam int CFG_LSB_FIRST_POS = 6;
    localparam logic [7:0] SERIAL_PORT_CONFIG_RESET = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Host controller registers over AHB-Lite (byte addresses).
    localparam logic [7:0] HOST_CMD_OFS = 8'h00;
    localparam logic [7:0] HOST_WDATA_OFS = 8'h04;
    localparam logic [7:0] HOST_RDATA_OFS = 8'h08;
    localparam logic [7:0] HOST_STATUS_OFS = 8'h0C;
    localparam logic [7:0] HOST_CTRL_OFS = 8'h10;
    localparam int CMD_START_POS = 31;
    localparam int CMD_RW_POS = 15;
    localparam int CTRL_LSB_FIRST_POS = 0;
    localparam int CTRL_HOLD_CS_POS = 1;
    // Serial clock made by the host: half period in system cycles.
    localparam int SYS_CLK_MHZ = 100;
    localparam int SCLK_HALF_NS = 80;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * SYS_CLK_MHZ) / 1000;
    localparam int CS_GAP_NS = 160;
    localparam int CS_GAP_CYC = (CS_GAP_NS * SYS_CLK_MHZ + 999) / 1000;
endpackage

// >>> test/config_serial_port_bench.sv
/*
 * Self-checking bench: AHB-Lite master on the host end, device end across the
 * link, and a second device driven bit by bit to break framing on purpose.
 * Assumes the host answers with zero wait states and reports busy in STATUS.
 */
module config_serial_port_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys;
    logic reset;
    logic hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0] cfgMain;
    logic strobeA, strobeB;
    logic [12:0] addrA, addrB;
    logic [7:0] dataA, dataB;
    logic [21:0] writeLog[$];
    int mismatches = 0;
    int checksDone = 0;

    csp_link_if mainLink();
    csp_link_if faultLink();

    csp_host csp_host_inst (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .hready(hreadyout), .link(mainLink.host));
    csp_device csp_device_inst (.clk_sys(clk_sys), .reset(reset), .link(mainLink.device),
        .cfgReg_q(cfgMain), .writeStrobe_q(strobeA), .writeAddr_q(addrA), .writeData_q(dataA));
    csp_device csp_device_inst2 (.clk_sys(clk_sys), .reset(reset), .link(faultLink.device),
        .cfgReg_q(), .writeStrobe_q(strobeB), .writeAddr_q(addrB), .writeData_q(dataB));
    csp_link_asserts csp_link_asserts_inst (.clk_sys(clk_sys), .reset(reset),
        .sclk(mainLink.sclk), .chipSelectN(mainLink.chipSelectN), .hostSdo(mainLink.hostSdo),
        .hostSdoEn(mainLink.hostSdoEn), .devSdo(mainLink.devSdo),
        .devSdoEn(mainLink.devSdoEn), .sdioLine(mainLink.sdioLine));

    // 100 MHz system clock.
    always #5 clk_sys = ~clk_sys;

    // Every byte either device writes is logged with the device it came from.
    always @(posedge clk_sys) begin
        if (strobeA === 1'b1) writeLog.push_back({1'b0, addrA, dataA});
        if (strobeB === 1'b1) writeLog.push_back({1'b1, addrB, dataB});
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // The log is drained in order, so a missing or extra byte shows up as a mismatch.
    task automatic expect_write(input logic dev, input logic [12:0] a, input logic [7:0] d);
        logic [21:0] got;
        got = (writeLog.size() > 0) ? writeLog.pop_front() : 22'h3FFFFF;
        check("written byte", {10'h000, dev, a, d}, {10'h000, got});
    endtask

    task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Launches one frame on the main link and waits until the host is idle again.
    task automatic frame(input logic rdn, input logic [1:0] len, input logic [12:0] a,
        input logic [31:0] wd);
        logic busy;
        busy = 1'b1;
        ahb_xfer(1'b1, csp_pkg::HOST_WDATA_OFS, wd);
        ahb_xfer(1'b1, csp_pkg::HOST_CMD_OFS, {16'h8000, rdn, len, a});
        repeat (4) @(posedge clk_sys);
        for (int i = 0; i < 600 && busy; i++) begin
            ahb_xfer(1'b0, csp_pkg::HOST_STATUS_OFS, 32'h00000000);
            busy = (rd[0] !== 1'b0);
        end
        check("host busy", 32'h00000000, {31'h0, busy});
        repeat (24) @(posedge clk_sys);
    endtask

    // Bench-driven host on the second link: top n bits of v, most significant first.
    task automatic fbits(input logic [15:0] v, input int n);
        for (int i = 15; i > 15 - n; i--) begin
            faultLink.hostSdo <= v[i];
            repeat (8) @(posedge clk_sys);
            faultLink.sclk <= 1'b1;
            repeat (8) @(posedge clk_sys);
            faultLink.sclk <= 1'b0;
        end
    endtask

    // The line is scrambled while deselected so a stale bit cannot pass for data.
    task automatic fcs(input logic level);
        faultLink.chipSelectN <= level;
        faultLink.hostSdo <= ~faultLink.hostSdo;
        repeat (16) @(posedge clk_sys);
    endtask

    task automatic test_reset_values();
        check("config register", {24'h0, csp_pkg::SERIAL_PORT_CONFIG_RESET}, {24'h0, cfgMain});
        ahb_xfer(1'b0, 8'h20, 32'h00000000);
        check("unmapped read", 32'h00000000, rd);
    endtask

    task automatic test_write_and_read();
        frame(1'b0, csp_pkg::LEN_THREE, 13'h0005, 32'h00A1B2C3);
        expect_write(1'b0, 13'h0005, 8'hA1);
        expect_write(1'b0, 13'h0004, 8'hB2);
        expect_write(1'b0, 13'h0003, 8'hC3);
        frame(1'b1, csp_pkg::LEN_ONE, 13'h0004, 32'h00000000);
        ahb_xfer(1'b0, csp_pkg::HOST_RDATA_OFS, 32'h00000000);
        check("read back byte", 32'h000000B2, {24'h0, rd[7:0]});
        check("no write on read", 32'h0, 32'(writeLog.size()));
    endtask

    task automatic test_stream_and_stall();
        fcs(1'b0);
        fbits({1'b0, csp_pkg::LEN_STREAM, 13'h000C}, 16);
        fbits(16'h1100, 8);
        fbits(16'h2200, 8);
        fbits(16'h3300, 8);
        fcs(1'b1);
        expect_write(1'b1, 13'h000C, 8'h11);
        expect_write(1'b1, 13'h000B, 8'h22);
        expect_write(1'b1, 13'h000A, 8'h33);
        fcs(1'b0);
        fbits({1'b0, csp_pkg::LEN_TWO, 13'h0002}, 16);
        fbits(16'h4400, 8);
        fcs(1'b1);
        fcs(1'b0);
        fbits(16'h5500, 8);
        fcs(1'b1);
        expect_write(1'b1, 13'h0002, 8'h44);
        expect_write(1'b1, 13'h0001, 8'h55);
    endtask

    task automatic test_abort_mid_byte();
        fcs(1'b0);
        fbits({1'b0, csp_pkg::LEN_ONE, 13'h0003}, 16);
        fbits(16'hF000, 4);
        fcs(1'b1);
        fcs(1'b0);
        fbits({1'b0, csp_pkg::LEN_ONE, 13'h0006}, 16);
        fbits(16'h7700, 8);
        fcs(1'b1);
        expect_write(1'b1, 13'h0006, 8'h77);
        check("stray writes", 32'h0, 32'(writeLog.size()));
    endtask

    // Data bytes are not palindromes, so a wrong bit order shows up.
    task automatic test_lsb_mode();
        frame(1'b0, csp_pkg::LEN_ONE, csp_pkg::SERIAL_PORT_CONFIG_ADDR, 32'h00404040);
        expect_write(1'b0, 13'h0000, 8'h40);
        check("config register", 32'h00000040, {24'h0, cfgMain});
        ahb_xfer(1'b1, csp_pkg::HOST_CTRL_OFS, 32'h00000001);
        frame(1'b0, csp_pkg::LEN_TWO, 13'h0007, 32'h00001E2D);
        expect_write(1'b0, 13'h0007, 8'h1E);
        expect_write(1'b0, 13'h0008, 8'h2D);
    endtask

    task automatic test_two_wire();
        ahb_xfer(1'b1, csp_pkg::HOST_CTRL_OFS, 32'h00000003);
        frame(1'b0, csp_pkg::LEN_ONE, 13'h0009, 32'h006C6C6C);
        expect_write(1'b0, 13'h0009, 8'h6C);
        frame(1'b1, csp_pkg::LEN_ONE, 13'h0009, 32'h00000000);
        ahb_xfer(1'b0, csp_pkg::HOST_RDATA_OFS, 32'h00000000);
        check("two wire read", 32'h0000006C, {24'h0, rd[7:0]});
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence; the second link idles deselected until its own scenarios.
    initial begin
        clk_sys = 1'b0;
        reset = 1'b1;
        hsel = 1'b1;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        faultLink.sclk = 1'b0;
        faultLink.chipSelectN = 1'b1;
        faultLink.hostSdo = 1'b0;
        faultLink.hostSdoEn = 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        test_reset_values();
        test_write_and_read();
        test_stream_and_stall();
        test_abort_mid_byte();
        test_lsb_mode();
        test_two_wire();
        tally_and_finish();
    end

    // The scenarios need under ten thousand cycles; twice that is the limit.
    initial begin
        #200000;
        mismatches++;
        tally_and_finish();
    end
endmodule

// >>> test/csp_link_asserts.sv
/*
 * Concurrent checks on the serial link between host end and device end.
 * Assumes it sits beside the link interface and sees its signals as plain inputs.
 */
module csp_link_asserts (
    // System
    input wire logic clk_sys,
    input wire logic reset,
    // Link
    input wire logic sclk,
    input wire logic chipSelectN,
    input wire logic hostSdo,
    input wire logic hostSdoEn,
    input wire logic devSdo,
    input wire logic devSdoEn,
    input wire logic sdioLine
);
    // Everything here lives in the one system clock domain.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // The shared line must never see two drivers, or read data would be corrupted.
    no_contention_a: assert property (!(hostSdoEn && devSdoEn))
        else $error("both ends drive the data line");
    idle_release_a: assert property (chipSelectN [*8] |-> !devSdoEn)
        else $error("device drives with select high");
    drive_after_fall_a: assert property ($rose(devSdoEn) |-> !sclk)
        else $error("device began driving while clock high");
    release_on_rise_a: assert property ($fell(devSdoEn) |-> (sclk || chipSelectN))
        else $error("device released outside a rising phase");
    select_rise_low_a: assert property ($rose(chipSelectN) |-> !sclk)
        else $error("select rose with clock high");
    select_fall_low_a: assert property ($fell(chipSelectN) |-> !sclk)
        else $error("select fell with clock high");
    // Data from the host stays put across the whole high phase, not just the edge.
    data_stable_high_a: assert property (sclk && $past(sclk) && hostSdoEn && $past(hostSdoEn)
        |-> $stable(hostSdo))
        else $error("host data moved while clock high");
    clock_high_len_a: assert property ($rose(sclk) |=> sclk [*7])
        else $error("serial clock high phase too short");
    line_follows_dev_a: assert property (devSdoEn && !hostSdoEn |-> sdioLine == devSdo)
        else $error("line does not carry device data");

    // Main traffic kinds seen on the wire.
    read_seen_c: cover property ($rose(devSdoEn));
    frame_seen_c: cover property ($fell(chipSelectN) ##[1:40] $rose(sclk));
    write_bit_c: cover property ($rose(sclk) && hostSdoEn);
endmodule
